/* shared/iml_pkg.sv */
package iml_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IML_IDX_MAIN_MASK   = 6'h16;
	localparam logic [5:0] IML_IDX_TIMER_MASK  = 6'h17;
	localparam logic [5:0] IML_IDX_ERROR_MASK  = 6'h18;
	localparam logic [5:0] IML_IDX_MAIN_STAT   = 6'h1A;
	localparam logic [5:0] IML_IDX_TIMER_STAT  = 6'h1B;
	localparam logic [5:0] IML_IDX_ERROR_STAT  = 6'h1C;

	// reset values
	localparam logic [7:0] IML_MASK_RESET      = 8'h00;
	localparam logic [7:0] IML_FLAG_RESET      = 8'h00;

	// main group field positions
	localparam int IML_MAIN_OSC        = 7;
	localparam int IML_MAIN_FIFO_LEVEL = 6;
	localparam int IML_MAIN_RX_START   = 5;
	localparam int IML_MAIN_RX_END     = 4;
	localparam int IML_MAIN_TX_END     = 3;
	localparam int IML_MAIN_COLLISION  = 2;
	localparam int IML_MAIN_RX_RESTART = 1;
	localparam int IML_MAIN_UNUSED     = 0;

	// timer and field group field positions
	localparam int IML_TMR_DIRECT_CMD  = 7;
	localparam int IML_TMR_NO_RESP     = 6;
	localparam int IML_TMR_GP_TIMER    = 5;
	localparam int IML_TMR_FIELD_ON    = 4;
	localparam int IML_TMR_FIELD_OFF   = 3;
	localparam int IML_TMR_CA_COLL     = 2;
	localparam int IML_TMR_GUARD_TIME  = 1;
	localparam int IML_TMR_BIT_RATE    = 0;

	// error and wake-up group field positions
	localparam int IML_ERR_CRC         = 7;
	localparam int IML_ERR_PARITY      = 6;
	localparam int IML_ERR_SOFT_FRAME  = 5;
	localparam int IML_ERR_HARD_FRAME  = 4;
	localparam int IML_ERR_WAKE_TIMER  = 3;
	localparam int IML_ERR_WAKE_AMPL   = 2;
	localparam int IML_ERR_WAKE_PHASE  = 1;
	localparam int IML_ERR_WAKE_CAP    = 0;

	// fifo count width in bits and level thresholds in bytes
	localparam int IML_FIFO_CNT_W      = 10;
	localparam int IML_RX_LEVEL        = 300;
	localparam int IML_TX_LEVEL        = 200;

	// one byte per interrupt group
	typedef struct packed {
		logic [7:0] mainIrq;
		logic [7:0] timerIrq;
		logic [7:0] errorIrq;
	} iml_irq_vec_t;

endpackage

/* verilog/iml_top.sv */
`timescale 1ns/1ps
module iml_top
	import iml_pkg::*;
#(
	parameter int FIFO_CNT_W = IML_FIFO_CNT_W,
	parameter int RX_LEVEL   = IML_RX_LEVEL,
	parameter int TX_LEVEL   = IML_TX_LEVEL
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// interrupt sources, one-cycle pulses
	input  wire iml_irq_vec_t          srcEvent,
	// fifo state for the level interrupt
	input  wire logic                  rxActive,
	input  wire logic                  txActive,
	input  wire logic [FIFO_CNT_W-1:0] fifoCount,
	// interrupt to the host
	output logic                       irqOut
);

	////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (FIFO_CNT_W < 2 || FIFO_CNT_W > 16) begin : g_bad_width
		$error("fifo count width out of range");
	end
	if (RX_LEVEL >= (1 << FIFO_CNT_W) || TX_LEVEL > (1 << FIFO_CNT_W))
	begin : g_bad_level
		$error("fifo level does not fit the count width");
	end

	////////////////////////////////////////////////////////////////////////
	// declarations

	iml_irq_vec_t          maskQ;
	iml_irq_vec_t          maskD;
	iml_irq_vec_t          flagsQ;
	iml_irq_vec_t          flagsD;
	iml_irq_vec_t          setVec;
	iml_irq_vec_t          clrVec;
	logic [31:0]           prdataQ;
	logic                  preadyQ;
	logic                  pslverrQ;
	logic                  irqQ;
	logic                  levelQ;
	logic                  levelNow;
	logic                  levelEvt;
	logic [5:0]            regIdx;
	logic                  aligned;
	logic                  mapped;
	logic                  setupPhase;
	logic                  xferDone;
	logic                  wrDone;
	logic                  rdDone;
	logic [7:0]            readByte;
	logic [FIFO_CNT_W-1:0] rxLevel;
	logic [FIFO_CNT_W-1:0] txLevel;

	assign rxLevel = FIFO_CNT_W'(RX_LEVEL);
	assign txLevel = FIFO_CNT_W'(TX_LEVEL);

	////////////////////////////////////////////////////////////////////////
	// apb decode

	assign regIdx     = paddr[7:2];
	assign aligned    = (paddr[1:0] == 2'b00);
	assign setupPhase = psel && !penable;
	// pready is registered in the setup phase, so every transfer completes with no wait state
	assign xferDone   = psel && penable && preadyQ;
	assign wrDone     = xferDone && pwrite && !pslverrQ;
	assign rdDone     = xferDone && !pwrite && !pslverrQ;

	always_comb begin
		mapped = aligned;
		unique case (regIdx)
			IML_IDX_MAIN_MASK,
			IML_IDX_TIMER_MASK,
			IML_IDX_ERROR_MASK,
			IML_IDX_MAIN_STAT,
			IML_IDX_TIMER_STAT,
			IML_IDX_ERROR_STAT: mapped = aligned;
			default:            mapped = 1'b0;
		endcase
	end

	always_comb begin
		unique case (regIdx)
			IML_IDX_MAIN_MASK:  readByte = maskQ.mainIrq;
			IML_IDX_TIMER_MASK: readByte = maskQ.timerIrq;
			IML_IDX_ERROR_MASK: readByte = maskQ.errorIrq;
			IML_IDX_MAIN_STAT:  readByte = flagsQ.mainIrq;
			IML_IDX_TIMER_STAT: readByte = flagsQ.timerIrq;
			IML_IDX_ERROR_STAT: readByte = flagsQ.errorIrq;
			default:            readByte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer, all from flip-flops

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdataQ  <= 32'h0000_0000;
			preadyQ  <= 1'b0;
			pslverrQ <= 1'b0;
		end else if (setupPhase) begin
			prdataQ  <= {24'h00_0000, readByte};
			preadyQ  <= 1'b1;
			pslverrQ <= !mapped;
		end else if (xferDone) begin
			preadyQ  <= 1'b0;
			pslverrQ <= 1'b0;
		end
	end

	assign prdata  = prdataQ;
	assign pready  = preadyQ;
	assign pslverr = pslverrQ;

	////////////////////////////////////////////////////////////////////////
	// mask registers

	always_comb begin
		maskD = maskQ;
		if (wrDone) begin
			unique case (regIdx)
				IML_IDX_MAIN_MASK:  maskD.mainIrq  = pwdata[7:0];
				IML_IDX_TIMER_MASK: maskD.timerIrq = pwdata[7:0];
				IML_IDX_ERROR_MASK: maskD.errorIrq = pwdata[7:0];
				// status registers are read only; writes are dropped
				default:            maskD = maskQ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			maskQ <= '{IML_MASK_RESET, IML_MASK_RESET, IML_MASK_RESET};
		end else begin
			maskQ <= maskD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fifo level event

	always_comb begin
		levelNow = (rxActive && (fifoCount > rxLevel)) ||
			(txActive && (fifoCount < txLevel));
	end

	// edge only, else a read could never clear a lasting level
	assign levelEvt = levelNow && !levelQ;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			levelQ <= 1'b0;
		end else begin
			levelQ <= levelNow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pending flags

	always_comb begin
		setVec = srcEvent;
		setVec.mainIrq[IML_MAIN_FIFO_LEVEL] = levelEvt;
		setVec.mainIrq[IML_MAIN_UNUSED]     = 1'b0;
	end

	// clear only what the host saw, so a late event is not lost
	always_comb begin
		clrVec = '0;
		if (rdDone) begin
			unique case (regIdx)
				IML_IDX_MAIN_STAT:  clrVec.mainIrq  = prdataQ[7:0];
				IML_IDX_TIMER_STAT: clrVec.timerIrq = prdataQ[7:0];
				IML_IDX_ERROR_STAT: clrVec.errorIrq = prdataQ[7:0];
				default:            clrVec = '0;
			endcase
		end
	end

	// set wins over clear
	assign flagsD = (flagsQ & ~clrVec) | setVec;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flagsQ <= '{IML_FLAG_RESET, IML_FLAG_RESET, IML_FLAG_RESET};
		end else begin
			flagsQ <= flagsD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt output

	// next-state values keep irq aligned with the flag and mask registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irqQ <= 1'b0;
		end else begin
			irqQ <= |(flagsD & ~maskD);
		end
	end

	assign irqOut = irqQ;

	////////////////////////////////////////////////////////////////////////
	// assertions

	logic [23:0] flatF;
	logic [23:0] flatM;

	assign flatF = flagsQ;
	assign flatM = maskQ;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	osc_mask_a: assert property (
		(flatF == 24'h80_0000 && flatM[23]) |-> !irqOut)
		else $error("oscillator interrupt not masked");

	level_mask_a: assert property (
		(flatF == 24'h40_0000 && flatM[22]) |-> !irqOut)
		else $error("fifo level interrupt not masked");

	rx_mask_a: assert property (
		((flatF == 24'h20_0000 && flatM[21]) ||
		(flatF == 24'h10_0000 && flatM[20])) |-> !irqOut)
		else $error("rx interrupt not masked");

	tx_mask_a: assert property (
		(flatF == 24'h08_0000 && flatM[19]) |-> !irqOut)
		else $error("tx end interrupt not masked");

	coll_mask_a: assert property (
		(flatF == 24'h04_0000 && flatM[18]) |-> !irqOut)
		else $error("collision interrupt not masked");

	restart_mask_a: assert property (
		((flatF == 24'h02_0000 && flatM[17]) |-> !irqOut) and
		(!flagsQ.mainIrq[IML_MAIN_UNUSED]))
		else $error("restart masked wrong or unused bit set");

	dct_mask_a: assert property (
		(flatF == 24'h00_8000 && flatM[15]) |-> !irqOut)
		else $error("direct command interrupt not masked");

	nrt_mask_a: assert property (
		(flatF == 24'h00_4000 && flatM[14]) |-> !irqOut)
		else $error("no-response interrupt not masked");

	gpt_mask_a: assert property (
		(flatF == 24'h00_2000 && flatM[13]) |-> !irqOut)
		else $error("gp timer interrupt not masked");

	field_mask_a: assert property (
		((flatF == 24'h00_1000 && flatM[12]) ||
		(flatF == 24'h00_0800 && flatM[11])) |-> !irqOut)
		else $error("field interrupt not masked");

	ca_mask_a: assert property (
		(flatF == 24'h00_0400 && flatM[10]) |-> !irqOut)
		else $error("collision avoidance interrupt not masked");

	guard_mask_a: assert property (
		(flatF == 24'h00_0200 && flatM[9]) |-> !irqOut)
		else $error("guard time interrupt not masked");

	rate_mask_a: assert property (
		(flatF == 24'h00_0100 && flatM[8]) |-> !irqOut)
		else $error("bit rate interrupt not masked");

	crc_par_mask_a: assert property (
		((flatF == 24'h00_0080 && flatM[7]) ||
		(flatF == 24'h00_0040 && flatM[6])) |-> !irqOut)
		else $error("crc or parity interrupt not masked");

	framing_mask_a: assert property (
		((flatF == 24'h00_0020 && flatM[5]) ||
		(flatF == 24'h00_0010 && flatM[4])) |-> !irqOut)
		else $error("framing interrupt not masked");

	wake_tmr_mask_a: assert property (
		(flatF == 24'h00_0008 && flatM[3]) |-> !irqOut)
		else $error("wake-up timer interrupt not masked");

	wake_meas_mask_a: assert property (
		((flatF == 24'h00_0004 && flatM[2]) ||
		(flatF == 24'h00_0002 && flatM[1]) ||
		(flatF == 24'h00_0001 && flatM[0])) |-> !irqOut)
		else $error("wake-up measurement interrupt not masked");

	read_clear_a: assert property (
		(rdDone && regIdx == IML_IDX_MAIN_STAT && srcEvent == '0 &&
		!levelEvt) |=> ((flagsQ.mainIrq & $past(prdataQ[7:0])) == 8'h00))
		else $error("status read did not clear flags");

	timer_clear_a: assert property (
		(rdDone && regIdx == IML_IDX_TIMER_STAT && srcEvent == '0) |=>
		((flagsQ.timerIrq & $past(prdataQ[7:0])) == 8'h00))
		else $error("timer status read did not clear flags");

	error_clear_a: assert property (
		(rdDone && regIdx == IML_IDX_ERROR_STAT && srcEvent == '0) |=>
		((flagsQ.errorIrq & $past(prdataQ[7:0])) == 8'h00))
		else $error("error status read did not clear flags");

	level_set_a: assert property (
		(rxActive && fifoCount > rxLevel && !levelQ) |=>
		flagsQ.mainIrq[IML_MAIN_FIFO_LEVEL])
		else $error("fifo level flag not raised");

	level_tx_a: assert property (
		(txActive && fifoCount < txLevel && !levelQ) |=>
		flagsQ.mainIrq[IML_MAIN_FIFO_LEVEL])
		else $error("fifo level flag not raised on transmit");

	irq_level_a: assert property (
		irqOut == (|(flatF & ~flatM)))
		else $error("interrupt output disagrees with flags");

	mask_write_a: assert property (
		(wrDone && regIdx == IML_IDX_TIMER_MASK) |=>
		(maskQ.timerIrq == $past(pwdata[7:0])) [*1] ##0
		(irqOut == (|(flatF & ~flatM))))
		else $error("mask write did not take effect");

	// masks only move on a completed write, never on their own
	mask_hold_a: assert property (
		!wrDone |=> (maskQ == $past(maskQ)))
		else $error("mask changed without a write");

	mask_write_c: cover property (wrDone && regIdx == IML_IDX_MAIN_MASK);
	stat_read_c:  cover property (rdDone && prdataQ[7:0] != 8'h00);
	irq_rise_c:   cover property (!irqOut ##1 irqOut);
	unmapped_c:   cover property (xferDone && pslverrQ);
	level_evt_c:  cover property (levelEvt ##1
		flagsQ.mainIrq[IML_MAIN_FIFO_LEVEL]);

endmodule // iml_top

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import iml_pkg::*;

	logic         clk_sys   = 1'b0;
	logic         reset_n   = 1'b0;
	logic         psel      = 1'b0;
	logic         penable   = 1'b0;
	logic         pwrite    = 1'b0;
	logic [7:0]   paddr     = 8'h00;
	logic [31:0]  pwdata    = 32'h0000_0000;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	iml_irq_vec_t srcEvent  = '0;
	logic         rxActive  = 1'b0;
	logic         txActive  = 1'b0;
	logic [9:0]   fifoCount = 10'h0fa;
	logic         irqOut;
	int           fails     = 0;
	int           checks    = 0;
	logic [33:0]  notes[$];
	logic [33:0]  note;
	logic [31:0]  seed      = 32'h306e_541a;

	always #2.5 clk_sys = ~clk_sys;

	iml_top dut (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.srcEvent  (srcEvent),
		.rxActive  (rxActive),
		.txActive  (txActive),
		.fifoCount (fifoCount),
		.irqOut    (irqOut)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] adr(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction

	// starts one edge later so psel is never assigned twice in a time step
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic err, input logic [31:0] exp);
		@(posedge clk_sys);
		notes.push_back({wr, err, exp});
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		apb(1'b1, adr(idx), d, 1'b0, 32'h0000_0000);
		#1;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, adr(idx), 32'h0000_0000, 1'b0, exp);
	endtask

	// one-cycle event pulse on one bit group; main group is the top byte
	task automatic pulse(input int g, input logic [7:0] bits);
		@(posedge clk_sys);
		srcEvent <= iml_irq_vec_t'(24'(bits) << (8 * (2 - g)));
		@(posedge clk_sys);
		srcEvent <= '0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// result watcher: a completed transfer retires the oldest note
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			check({31'h0, pslverr}, {31'h0, note[32]});
			if (!note[33]) begin
				check(prdata, note[31:0]);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin : mainSeq
		logic [7:0] bitV;
		logic       live;
		logic [5:0] mIdx;
		logic [5:0] sIdx;
		logic [7:0] mainMaskV;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1 check({31'h0, irqOut}, 32'h0000_0000);
		for (int g = 0; g < 3; g++) begin
			rd(IML_IDX_MAIN_MASK + 6'(g), 32'h0000_0000);
			rd(IML_IDX_MAIN_STAT + 6'(g), 32'h0000_0000);
		end
		$display("reset values done");
		for (int g = 0; g < 3; g++) begin
			seed = lfsr(seed);
			if (g == 0) begin
				mainMaskV = seed[7:0];
			end
			wr(IML_IDX_MAIN_MASK + 6'(g), seed);
			rd(IML_IDX_MAIN_MASK + 6'(g), {24'h0, seed[7:0]});
		end
		$display("mask read back done");
		// status registers are read-only; bad addresses are refused
		apb(1'b0, 8'h00, 32'h0000_0000, 1'b1, 32'h0000_0000);
		// a misaligned read still returns the byte of its word index
		apb(1'b0, 8'h59, 32'h0000_0000, 1'b1, {24'h00_0000, mainMaskV});
		apb(1'b1, 8'h04, 32'h0000_00ff, 1'b1, 32'h0000_0000);
		wr(IML_IDX_MAIN_STAT, 32'h0000_00ff);
		rd(IML_IDX_MAIN_STAT, 32'h0000_0000);
		$display("refused access done");
		for (int g = 0; g < 3; g++) begin
			mIdx = IML_IDX_MAIN_MASK + 6'(g);
			sIdx = IML_IDX_MAIN_STAT + 6'(g);
			for (int b = 0; b < 8; b++) begin
				bitV = 8'h01 << b;
				// main bit 0 is unused, main bit 6 only follows the fifo
				live = !(g == 0 && (b == 0 || b == 6));
				wr(mIdx, {24'h0, bitV});
				pulse(g, bitV);
				check({31'h0, irqOut}, 32'h0000_0000);
				wr(mIdx, 32'h0000_0000);
				check({31'h0, irqOut}, {31'h0, live});
				wr(mIdx, {24'h0, bitV});
				check({31'h0, irqOut}, 32'h0000_0000);
				rd(sIdx, live ? {24'h0, bitV} : 32'h0000_0000);
				rd(sIdx, 32'h0000_0000);
				wr(mIdx, 32'h0000_0000);
				check({31'h0, irqOut}, 32'h0000_0000);
			end
		end
		$display("mask bits done");
		// boundary counts each side of both thresholds
		// level event masked at i == 1, unmasked at i == 3
		for (int i = 0; i < 4; i++) begin
			wr(IML_IDX_MAIN_MASK,
				(i == 1) ? 32'h0000_0040 : 32'h0000_0000);
			@(posedge clk_sys);
			rxActive  <= (i < 2);
			txActive  <= (i >= 2);
			fifoCount <= (i == 0) ? 10'h12c : (i == 1) ? 10'h12d :
				(i == 2) ? 10'h0c8 : 10'h0c7;
			@(posedge clk_sys);
			@(posedge clk_sys);
			rxActive  <= 1'b0;
			txActive  <= 1'b0;
			fifoCount <= 10'h0fa;
			#1 check({31'h0, irqOut}, {31'h0, i == 3});
			rd(IML_IDX_MAIN_STAT, i[0] ? 32'h0000_0040 : 32'h0000_0000);
		end
		$display("fifo level done");
		repeat (4) @(posedge clk_sys);
		test_done();
	end
endmodule // testbench
